// ### verilog/fdwp_cfg.svh
`ifndef FDWP_CFG_SVH
`define FDWP_CFG_SVH

// register byte offsets
`define FDWP_OFF_CTRL    8'h00
`define FDWP_OFF_KEY     8'h04
`define FDWP_OFF_ADRL    8'h08
`define FDWP_OFF_ADRH    8'h0C
`define FDWP_OFF_PAGE    8'h10
`define FDWP_OFF_PTR     8'h14
`define FDWP_OFF_TWL     8'h18
`define FDWP_OFF_TWH     8'h1C
`define FDWP_OFF_STAT    8'h20
`define FDWP_OFF_MASK    8'h24

// flash_op_control field positions
`define FDWP_BIT_TRIG    15
`define FDWP_BIT_ALLOW   14
`define FDWP_BIT_FAULT   13
`define FDWP_BIT_SWAP    11
`define FDWP_BIT_P2      10
`define FDWP_OP_MSB      3

// operation codes
`define FDWP_OP_DWORD    4'h1
`define FDWP_OP_ERASE    4'h3

// unlock keys and latch page
`define FDWP_KEY_FIRST   16'h0055
`define FDWP_KEY_SECOND  16'h00AA
`define FDWP_LATCH_PAGE  8'hFA

// interrupt status bit positions
`define FDWP_IRQ_DONE    0
`define FDWP_IRQ_FAULT   1

// reset values
`define FDWP_RST_WORD    24'h000000
`define FDWP_RST_REG16   16'h0000
`define FDWP_RST_REG8    8'h00
`define FDWP_RST_OP      4'h0
`define FDWP_RST_IRQ     2'h0

`endif

// ### verilog/fdwp_pkg.sv
package fdwp_pkg;

    typedef logic [23:0] fdwp_word_t;

    typedef enum logic [0:0]
    {
        st_idle = 1'b0,
        st_run  = 1'b1
    } fdwp_state_t;

endpackage

// ### verilog/fdwp_latch_if.sv
`timescale 1ns/10ps
interface fdwp_latch_if;
    logic                 wr_lo;
    logic                 wr_hi;
    logic                 sel;
    logic [15:0]          data;
    fdwp_pkg::fdwp_word_t word0;
    fdwp_pkg::fdwp_word_t word1;

    modport ctl  (output wr_lo, output wr_hi, output sel, output data,
                  input word0, input word1);
    modport hold (input wr_lo, input wr_hi, input sel, input data,
                  output word0, output word1);
endinterface

// ### verilog/fdwp_latch.sv
`timescale 1ns/10ps
`include "fdwp_cfg.svh"
module fdwp_latch
(
    input  wire logic   clock,
    input  wire logic   rst_b,
    fdwp_latch_if.hold  lat
);
    import fdwp_pkg::*;

    fdwp_word_t mem_q [2];

    // table writes land here, never in the flash array itself
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            mem_q[0] <= `FDWP_RST_WORD;
            mem_q[1] <= `FDWP_RST_WORD;
        end
        else if (lat.wr_lo)
            mem_q[lat.sel][15:0] <= lat.data;
        else if (lat.wr_hi)
            mem_q[lat.sel][23:16] <= lat.data[7:0];
    end

    assign lat.word0 = mem_q[0];
    assign lat.word1 = mem_q[1];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_latch_lo;
        logic s;
        logic [15:0] d;
        (lat.wr_lo, s = lat.sel, d = lat.data) |=>
            (s ? lat.word1[15:0] : lat.word0[15:0]) == d;
    endproperty
    a_latch_lo: assert property (p_latch_lo) else $error("latch low word not stored");

    property p_latch_hi;
        logic s;
        logic [7:0] d;
        (lat.wr_hi && !lat.wr_lo, s = lat.sel, d = lat.data[7:0]) |=>
            (s ? lat.word1[23:16] : lat.word0[23:16]) == d;
    endproperty
    a_latch_hi: assert property (p_latch_hi) else $error("latch upper byte not stored");

endmodule // fdwp_latch

// ### verilog/fdwp_unlock.sv
`timescale 1ns/10ps
`include "fdwp_cfg.svh"
module fdwp_unlock
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        key_wr,
    input  wire logic        other_wr,
    input  wire logic [15:0] key_data,
    output logic             armed
);
    import fdwp_pkg::*;

    logic first_q;
    logic armed_q;

    // any write that is not the next key breaks the sequence
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            first_q <= 1'b0;
            armed_q <= 1'b0;
        end
        else if (key_wr)
        begin
            first_q <= (key_data == `FDWP_KEY_FIRST);
            armed_q <= first_q && (key_data == `FDWP_KEY_SECOND);
        end
        else if (other_wr)
        begin
            first_q <= 1'b0;
            armed_q <= 1'b0;
        end
    end

    assign armed = armed_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // one quiet cycle between the keys, as a bus master with spaced writes gives
    sequence s_keys;
        key_wr && key_data == `FDWP_KEY_FIRST ##1 (!key_wr && !other_wr)
            ##1 key_wr && key_data == `FDWP_KEY_SECOND;
    endsequence

    property p_arm_pair;
        s_keys |=> armed_q;
    endproperty
    a_arm_pair: assert property (p_arm_pair) else $error("key pair did not arm");

    property p_arm_cause;
        $rose(armed_q) |-> $past(key_wr) && $past(key_data) == `FDWP_KEY_SECOND
            && $past(first_q);
    endproperty
    a_arm_cause: assert property (p_arm_cause) else $error("armed without key pair");

endmodule // fdwp_unlock

// ### verilog/fdwp_top.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "fdwp_cfg.svh"
module fdwp_top
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        por_b,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [15:0] rd_data,
    output logic             irq,
    input  wire logic        dual_partition_mode,
    input  wire logic        partition2_mapped,
    input  wire logic        soft_swap_done,
    output logic      [23:0] flash_addr,
    output logic      [47:0] flash_wdata,
    output logic             flash_program,
    output logic             flash_erase,
    input  wire logic        flash_done,
    input  wire logic        flash_abort
);
    import fdwp_pkg::*;

    fdwp_state_t state_q;
    logic        trig_q;
    logic        allow_q;
    logic        fault_q;
    logic [3:0]  op_q;
    logic [15:0] adrl_q;
    logic [7:0]  adrh_q;
    logic [7:0]  page_q;
    logic [15:0] ptr_q;
    logic [1:0]  stat_q;
    logic [1:0]  stat_d;
    logic [1:0]  mask_q;
    logic        p2_q;
    logic        swap_q;
    logic [15:0] rd_data_q;
    logic        irq_q;
    logic [23:0] flash_addr_q;
    logic [47:0] flash_wdata_q;
    logic        flash_program_q;
    logic        flash_erase_q;

    logic        ctrl_wr;
    logic        key_wr;
    logic        page_ok;
    logic        trig_req;
    logic        op_legal;
    logic        start;
    logic        reject;
    logic        done_ok;
    logic        done_bad;
    logic        armed;
    logic [15:0] ctrl_view;
    logic [15:0] rd_mux;

    fdwp_latch_if lat ();

    assign ctrl_wr  = wr_en && addr == `FDWP_OFF_CTRL;
    assign key_wr   = wr_en && addr == `FDWP_OFF_KEY;
    assign page_ok  = page_q == `FDWP_LATCH_PAGE;
    assign trig_req = ctrl_wr && wr_data[`FDWP_BIT_TRIG] && state_q == st_idle;
    assign op_legal = wr_data[`FDWP_OP_MSB:0] == `FDWP_OP_DWORD
                   || wr_data[`FDWP_OP_MSB:0] == `FDWP_OP_ERASE;
    // the trigger write itself must carry allow and opcode, as 0xC001 does; the allow
    // and opcode stored by an earlier 0x4001-style write are not used for the start
    assign start    = trig_req && armed && wr_data[`FDWP_BIT_ALLOW] && op_legal;
    assign reject   = trig_req && !start;
    assign done_ok  = state_q == st_run && flash_done && !flash_abort;
    assign done_bad = state_q == st_run && flash_abort;

    // latch page must be selected first, else the table write is dropped
    assign lat.wr_lo = wr_en && addr == `FDWP_OFF_TWL && page_ok;
    assign lat.wr_hi = wr_en && addr == `FDWP_OFF_TWH && page_ok;
    assign lat.sel   = ptr_q[1];
    assign lat.data  = wr_data;

    fdwp_latch u_latch
    (
        .clock (clock),
        .rst_b (rst_b),
        .lat   (lat)
    );

    fdwp_unlock u_unlock
    (
        .clock    (clock),
        .rst_b    (rst_b),
        .key_wr   (key_wr),
        .other_wr (wr_en && !key_wr),
        .key_data (wr_data),
        .armed    (armed)
    );

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            state_q <= st_idle;
        else
        begin
            unique case (state_q)
                st_idle:
                    if (start)
                        state_q <= st_run;
                st_run:
                    if (flash_done || flash_abort)
                        state_q <= st_idle;
            endcase
        end
    end

    // trigger is set-only from software and held for the whole operation
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            trig_q <= 1'b0;
        else if (start)
            trig_q <= 1'b1;
        else if (done_ok || done_bad)
            trig_q <= 1'b0;
    end

    // these bits survive a system reset and clear only on power-on
    always_ff @(posedge clock)
    begin
        if (!por_b)
        begin
            allow_q <= 1'b0;
            op_q    <= `FDWP_RST_OP;
        end
        else if (ctrl_wr && state_q == st_idle)
        begin
            allow_q <= wr_data[`FDWP_BIT_ALLOW];
            op_q    <= wr_data[`FDWP_OP_MSB:0];
        end
    end

    // set wins over the software clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (!por_b)
            fault_q <= 1'b0;
        else if (reject || done_bad)
            fault_q <= 1'b1;
        else if (done_ok)
            fault_q <= 1'b0;
        else if (ctrl_wr && state_q == st_idle && !wr_data[`FDWP_BIT_FAULT])
            fault_q <= 1'b0;
    end

    // address pair and page are frozen while an operation runs
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            adrl_q <= `FDWP_RST_REG16;
            adrh_q <= `FDWP_RST_REG8;
            page_q <= `FDWP_RST_REG8;
            ptr_q  <= `FDWP_RST_REG16;
            mask_q <= `FDWP_RST_IRQ;
        end
        else if (wr_en && state_q == st_idle)
        begin
            if (addr == `FDWP_OFF_ADRL)
                adrl_q <= wr_data;
            if (addr == `FDWP_OFF_ADRH)
                adrh_q <= wr_data[7:0];
            if (addr == `FDWP_OFF_PAGE)
                page_q <= wr_data[7:0];
            if (addr == `FDWP_OFF_PTR)
                ptr_q <= wr_data;
            if (addr == `FDWP_OFF_MASK)
                mask_q <= wr_data[1:0];
        end
    end

    // flash macro command; the macro is self-timed and answers with done or abort
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            flash_addr_q    <= `FDWP_RST_WORD;
            flash_wdata_q   <= {`FDWP_RST_WORD, `FDWP_RST_WORD};
            flash_program_q <= 1'b0;
            flash_erase_q   <= 1'b0;
        end
        else if (start)
        begin
            flash_addr_q    <= {adrh_q, adrl_q};
            flash_wdata_q   <= {lat.word1, lat.word0};
            flash_program_q <= wr_data[`FDWP_OP_MSB:0] == `FDWP_OP_DWORD;
            flash_erase_q   <= wr_data[`FDWP_OP_MSB:0] == `FDWP_OP_ERASE;
        end
        else if (done_ok || done_bad)
        begin
            flash_program_q <= 1'b0;
            flash_erase_q   <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            p2_q   <= 1'b0;
            swap_q <= 1'b0;
        end
        else
        begin
            p2_q   <= dual_partition_mode && partition2_mapped;
            swap_q <= dual_partition_mode && soft_swap_done;
        end
    end

    // read-to-clear status; a new event in the read cycle stays set
    always_comb
    begin
        stat_d = stat_q;
        if (rd_en && addr == `FDWP_OFF_STAT)
            stat_d = `FDWP_RST_IRQ;
        stat_d[`FDWP_IRQ_DONE]  = stat_d[`FDWP_IRQ_DONE] || done_ok;
        stat_d[`FDWP_IRQ_FAULT] = stat_d[`FDWP_IRQ_FAULT] || reject || done_bad;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            stat_q <= `FDWP_RST_IRQ;
            irq_q  <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            irq_q  <= |(stat_d & mask_q);
        end
    end

    always_comb
    begin
        ctrl_view                      = `FDWP_RST_REG16;
        ctrl_view[`FDWP_BIT_TRIG]      = trig_q;
        ctrl_view[`FDWP_BIT_ALLOW]     = allow_q;
        ctrl_view[`FDWP_BIT_FAULT]     = fault_q;
        ctrl_view[`FDWP_BIT_SWAP]      = swap_q;
        ctrl_view[`FDWP_BIT_P2]        = p2_q;
        ctrl_view[`FDWP_OP_MSB:0]      = op_q;
    end

    always_comb
    begin
        unique case (addr)
            `FDWP_OFF_CTRL: rd_mux = ctrl_view;
            `FDWP_OFF_ADRL: rd_mux = adrl_q;
            `FDWP_OFF_ADRH: rd_mux = {8'h00, adrh_q};
            `FDWP_OFF_PAGE: rd_mux = {8'h00, page_q};
            `FDWP_OFF_PTR:  rd_mux = ptr_q;
            `FDWP_OFF_STAT: rd_mux = {14'h0000, stat_q};
            `FDWP_OFF_MASK: rd_mux = {14'h0000, mask_q};
            default:        rd_mux = `FDWP_RST_REG16;
        endcase
    end

    // key and latch ports are write-only and read as zero
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            rd_data_q <= `FDWP_RST_REG16;
        else if (rd_en)
            rd_data_q <= rd_mux;
        else
            rd_data_q <= `FDWP_RST_REG16;
    end

    assign rd_data       = rd_data_q;
    assign irq           = irq_q;
    assign flash_addr    = flash_addr_q;
    assign flash_wdata   = flash_wdata_q;
    assign flash_program = flash_program_q;
    assign flash_erase   = flash_erase_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b || !por_b);

    sequence s_launch;
        state_q == st_idle ##1 state_q == st_run;
    endsequence

    property p_allow_gate;
        s_launch |-> allow_q && trig_q;
    endproperty
    a_allow_gate: assert property (p_allow_gate) else $error("op ran without allow");

    property p_fault_reject;
        reject |=> fault_q && state_q == st_idle;
    endproperty
    a_fault_reject: assert property (p_fault_reject) else $error("bad trigger not flagged");

    property p_fault_clean;
        done_ok |=> !fault_q && stat_q[`FDWP_IRQ_DONE];
    endproperty
    a_fault_clean: assert property (p_fault_clean) else $error("fault after clean finish");

    property p_p2_live;
        ##1 p2_q == $past(dual_partition_mode && partition2_mapped);
    endproperty
    a_p2_live: assert property (p_p2_live) else $error("partition status wrong");

    property p_wdata;
        $rose(flash_program_q) |-> flash_wdata_q == {$past(lat.word1), $past(lat.word0)};
    endproperty
    a_wdata: assert property (p_wdata) else $error("program data not from latch");

    property p_target;
        $rose(flash_program_q || flash_erase_q) |->
            flash_addr_q == {$past(adrh_q), $past(adrl_q)};
    endproperty
    a_target: assert property (p_target) else $error("target address wrong");

    property p_opsel;
        $rose(flash_program_q) |-> op_q == `FDWP_OP_DWORD && !flash_erase_q;
    endproperty
    a_opsel: assert property (p_opsel) else $error("program without opcode 0001");

    property p_no_key;
        trig_req && !armed |=> state_q == st_idle && !trig_q;
    endproperty
    a_no_key: assert property (p_no_key) else $error("trigger accepted without unlock");

    property p_trig_hold;
        state_q == st_run |-> trig_q && (flash_program_q || flash_erase_q);
    endproperty
    a_trig_hold: assert property (p_trig_hold) else $error("trigger dropped early");

    property p_trig_clear;
        state_q == st_run && (flash_done || flash_abort) |=>
            !trig_q && !flash_program_q && !flash_erase_q;
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared");

endmodule // fdwp_top

// ### sim/fdwp_tb.sv
`timescale 1ns/10ps
`include "fdwp_cfg.svh"
module testbench;
    import fdwp_pkg::*;

    logic        clock;
    logic        rst_b;
    logic        por_b;
    logic [7:0]  addr;
    logic [15:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [15:0] rd_data;
    logic        irq;
    logic        dual_partition_mode;
    logic        partition2_mapped;
    logic        soft_swap_done;
    logic [23:0] flash_addr;
    logic [47:0] flash_wdata;
    logic        flash_program;
    logic        flash_erase;
    logic        flash_done;
    logic        flash_abort;
    int          bad_count;
    int          checked;
    int          cycles;
    logic [15:0] rv;
    logic [47:0] lw;
    logic [23:0] ta;
    int          nk   [5] = '{0, 1, 3, 2, 2};
    logic [15:0] cv   [5] = '{16'hC001, 16'hC001, 16'hC001, 16'h8001, 16'hC002};

    fdwp_top DUT
    (
        .clock               (clock),
        .rst_b               (rst_b),
        .por_b               (por_b),
        .addr                (addr),
        .wr_data             (wr_data),
        .wr_en               (wr_en),
        .rd_en               (rd_en),
        .rd_data             (rd_data),
        .irq                 (irq),
        .dual_partition_mode (dual_partition_mode),
        .partition2_mapped   (partition2_mapped),
        .soft_swap_done      (soft_swap_done),
        .flash_addr          (flash_addr),
        .flash_wdata         (flash_wdata),
        .flash_program       (flash_program),
        .flash_erase         (flash_erase),
        .flash_done          (flash_done),
        .flash_abort         (flash_abort)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic close_out;
        $display("compared %0d, wrong %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ceiling far above the few hundred cycles the tests need
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 4000)
        begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: run did not finish", $time);
            close_out();
        end
    end

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %b want %b", $time, m, got, exp);
        end
    endtask

    task automatic chk_bus(input logic [47:0] got, input logic [47:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en   <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic start(input logic [15:0] c);
        wr(`FDWP_OFF_KEY, `FDWP_KEY_FIRST);
        wr(`FDWP_OFF_KEY, `FDWP_KEY_SECOND);
        wr(`FDWP_OFF_CTRL, c);
        #1;
    endtask

    task automatic prog(input logic [7:0] pg, input logic [47:0] w, input logic [23:0] a);
        wr(`FDWP_OFF_PAGE, {8'h00, pg});
        wr(`FDWP_OFF_PTR, 16'h0000);
        wr(`FDWP_OFF_TWL, w[15:0]);
        wr(`FDWP_OFF_TWH, {8'h00, w[23:16]});
        wr(`FDWP_OFF_PTR, 16'h0002);
        wr(`FDWP_OFF_TWL, w[39:24]);
        wr(`FDWP_OFF_TWH, {8'h00, w[47:40]});
        wr(`FDWP_OFF_ADRL, a[15:0]);
        wr(`FDWP_OFF_ADRH, {8'h00, a[23:16]});
        wr(`FDWP_OFF_CTRL, 16'h4001);
        start(16'hC001);
    endtask

    task automatic op_end(input logic ab);
        @(posedge clock);
        flash_abort <= ab;
        flash_done  <= ~ab;
        @(posedge clock);
        flash_abort <= 1'b0;
        flash_done  <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic part(input logic d, input logic p, input logic [1:0] e);
        @(posedge clock);
        dual_partition_mode <= d;
        partition2_mapped   <= p;
        soft_swap_done      <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`FDWP_OFF_CTRL, rv);
        chk_reg({14'h0000, rv[11:10]}, {14'h0000, e}, "partition bits");
    endtask

    initial
    begin
        rst_b = 1'b0; por_b = 1'b0; addr = 8'h00; wr_data = 16'h0000;
        wr_en = 1'b0; rd_en = 1'b0; flash_done = 1'b0; flash_abort = 1'b0;
        dual_partition_mode = 1'b0; partition2_mapped = 1'b0; soft_swap_done = 1'b0;
        bad_count = 0; checked = 0; cycles = 0;
        lw = 48'hA5C3_E1F0_7B69;
        ta = 24'h12_3456;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        rd(`FDWP_OFF_CTRL, rv); chk_reg(rv, 16'h0000, "ctrl after reset");
        rd(`FDWP_OFF_STAT, rv); chk_reg(rv, 16'h0000, "status after reset");
        rd(8'h40, rv); chk_reg(rv, 16'h0000, "unmapped read");
        chk_bit(irq, 1'b0, "irq after reset");
        $display("test reset done");

        wr(`FDWP_OFF_MASK, 16'h0003);
        // wrong page: the latch keeps its cleared contents
        prog(8'h00, lw, ta);
        chk_bit(flash_program, 1'b1, "program start");
        chk_bus(flash_wdata, 48'h0, "latch guarded");
        op_end(1'b0);
        rd(`FDWP_OFF_STAT, rv); chk_reg(rv, 16'h0001, "done status");
        prog(`FDWP_LATCH_PAGE, lw, ta);
        chk_bit(flash_program, 1'b1, "program start");
        chk_bus({24'h0, flash_addr}, {24'h0, ta}, "target");
        chk_bus(flash_wdata, lw, "two words");
        rd(`FDWP_OFF_CTRL, rv); chk_reg(rv, 16'hC001, "ctrl running");
        rd(`FDWP_OFF_ADRL, rv); chk_reg(rv, ta[15:0], "addr low");
        rd(`FDWP_OFF_ADRH, rv); chk_reg(rv, {8'h00, ta[23:16]}, "addr high");
        chk_bit(flash_program, 1'b1, "still running");
        op_end(1'b0);
        chk_bit(flash_program, 1'b0, "program end");
        rd(`FDWP_OFF_CTRL, rv); chk_reg(rv, 16'h4001, "ctrl done");
        chk_bit(irq, 1'b1, "irq done");
        rd(`FDWP_OFF_STAT, rv); chk_reg(rv, 16'h0001, "done status");
        rd(`FDWP_OFF_STAT, rv); chk_reg(rv, 16'h0000, "status cleared");
        repeat (2) @(posedge clock);
        #1;
        chk_bit(irq, 1'b0, "irq cleared");
        $display("test program done");

        // missing key, lone key, broken pair, allow low, bad opcode
        for (int i = 0; i < 5; i++)
        begin
            wr(`FDWP_OFF_CTRL, 16'h4001);
            if (nk[i] >= 1) wr(`FDWP_OFF_KEY, `FDWP_KEY_FIRST);
            if (nk[i] >= 2) wr(`FDWP_OFF_KEY, `FDWP_KEY_SECOND);
            if (nk[i] == 3) wr(`FDWP_OFF_MASK, 16'h0003);
            wr(`FDWP_OFF_CTRL, cv[i]);
            #1;
            chk_bit(flash_program | flash_erase, 1'b0, "rejected");
            rd(`FDWP_OFF_CTRL, rv);
            chk_reg({14'h0, rv[15], rv[13]}, 16'h0001, "fault set");
            rd(`FDWP_OFF_STAT, rv); chk_reg(rv, 16'h0002, "fault status");
        end
        $display("test reject done");

        wr(`FDWP_OFF_CTRL, 16'h4001);
        start(16'hC001);
        chk_bit(flash_program, 1'b1, "program start");
        op_end(1'b1);
        chk_bit(flash_program, 1'b0, "aborted");
        rd(`FDWP_OFF_CTRL, rv); chk_reg(rv, 16'h6001, "abort fault");
        rd(`FDWP_OFF_STAT, rv); chk_reg(rv, 16'h0002, "abort status");
        $display("test abort done");

        // masked completion must leave irq low
        wr(`FDWP_OFF_MASK, 16'h0000);
        wr(`FDWP_OFF_CTRL, 16'h4003);
        start(16'hC003);
        chk_bus({46'h0, flash_erase, flash_program}, 48'h2, "erase start");
        op_end(1'b0);
        chk_bit(flash_erase, 1'b0, "erase end");
        chk_bit(irq, 1'b0, "irq masked");
        rd(`FDWP_OFF_STAT, rv); chk_reg(rv, 16'h0001, "erase status");
        $display("test erase done");

        part(1'b1, 1'b1, 2'b11);
        part(1'b1, 1'b0, 2'b10);
        part(1'b0, 1'b1, 2'b00);
        $display("test partition done");
        close_out();
    end
endmodule // testbench
